// [verilog/windowed_watchdog_timer.sv]
// Windowed watchdog timer with Wishbone register access
`timescale 1ns/1ps

module windowed_watchdog_timer
   import wdt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic low_power_rc_osc_clk_in,
   input wire core_evt_s core_evt,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [SEL_W-1:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic low_power_rc_osc_enable,
   output logic wdt_reset,
   output logic wdt_wake
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Ratio minus one of the postscaler for a select code
   function automatic logic [POST_W-1:0] post_last_f(input logic [3:0] sel);
      post_last_f = (POST_ONE << sel) - POST_ONE;
   endfunction

   // Last prescaler count for the chosen division
   function automatic logic [PRE_W-1:0] pre_last_f(input logic ratio_sel);
      pre_last_f = ratio_sel ? PRE_LAST_DIV128 : PRE_LAST_DIV32;
   endfunction

   // Address match for one register word
   function automatic logic hit_f(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] reg_adr);
      hit_f = (adr == reg_adr);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [2:0] low_power_rc_osc_sync_q;
   logic low_power_rc_osc_lvl_q;
   logic low_power_rc_osc_tick;
   logic [7:0] config_q;
   wdt_cfg_s cfg;
   logic soft_enable_q;
   logic timeout_flag_q;
   logic sleep_flag_q;
   logic idle_flag_q;
   power_mode_e mode_q;
   logic [PRE_W-1:0] pre_cnt_q;
   logic [POST_W-1:0] post_cnt_q;
   logic running;
   logic pre_wrap;
   logic timeout;
   logic [ELAPSED_W-1:0] elapsed;
   logic [TOTAL_W-1:0] total;
   logic window_open;
   logic windowed;
   logic clear_ok;
   logic clear_early;
   logic wdt_fire;
   logic wake_fire;
   logic enter_save;
   logic leave_save;
   logic dev_reset_any;
   logic counts_clear;
   logic bus_req;
   logic bus_wr;
   logic wr_rc;
   logic wr_cfg;
   logic [DAT_W-1:0] rd_data;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator tick recovery

   // Three-stage sampling; a level is accepted once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_rc_osc_sync_q <= 3'h0;
      end else begin
         low_power_rc_osc_sync_q <= {low_power_rc_osc_sync_q[1:0], low_power_rc_osc_clk_in};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_rc_osc_lvl_q <= 1'b0;
      end else if (low_power_rc_osc_sync_q[1] == low_power_rc_osc_sync_q[2]) begin
         low_power_rc_osc_lvl_q <= low_power_rc_osc_sync_q[2];
      end
   end

   // One tick per accepted rising edge of the oscillator
   assign low_power_rc_osc_tick = (low_power_rc_osc_sync_q[1] == low_power_rc_osc_sync_q[2]) && low_power_rc_osc_sync_q[2] && !low_power_rc_osc_lvl_q;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and enables

   assign cfg.config_enable = config_q[CW_ENABLE_BIT];
   assign cfg.window_disable = config_q[CW_WINDOW_DIS_BIT];
   assign cfg.prescale_ratio_select = config_q[CW_PRESCALE_BIT];
   assign cfg.postscale_select = config_q[CW_PS_HI:CW_PS_LO];

   // Configuration bit wins; the soft bit only matters when it is zero
   assign running = cfg.config_enable | soft_enable_q;
   // Window is armed only by a cleared disable bit; the enable bit is software's duty
   assign windowed = !cfg.window_disable;

   ////////////////////////////////////////////////////////////////////////////
   // Time-out and window decode

   // Prescaler wraps every 32 or 128 ticks, about 1 ms or 4 ms at nominal rate
   assign pre_wrap = low_power_rc_osc_tick && (pre_cnt_q == pre_last_f(cfg.prescale_ratio_select));
   assign timeout = running && pre_wrap
      && (post_cnt_q == post_last_f(cfg.postscale_select));

   // Elapsed and total oscillator ticks of the programmed period
   assign elapsed = cfg.prescale_ratio_select
      ? ELAPSED_W'({post_cnt_q, pre_cnt_q})
      : ELAPSED_W'({post_cnt_q, pre_cnt_q[PRE_SHIFT_DIV32-1:0]});
   assign total = cfg.prescale_ratio_select
      ? (TOTAL_W'(1) << (PRE_SHIFT_DIV128 + int'(cfg.postscale_select)))
      : (TOTAL_W'(1) << (PRE_SHIFT_DIV32 + int'(cfg.postscale_select)));
   // Final quarter starts at three quarters of the period
   assign window_open = TOTAL_W'(elapsed) >= (total - (total >> 2));

   // Clear instruction only counts in normal execution
   assign clear_ok = core_evt.clear_watchdog_instr && (mode_q == MODE_RUN)
      && (!windowed || window_open);
   assign clear_early = core_evt.clear_watchdog_instr && (mode_q == MODE_RUN)
      && running && windowed && !window_open;

   // Time-out resets in run mode and wakes in power save
   assign wdt_fire = (timeout && (mode_q == MODE_RUN)) || clear_early;
   assign wake_fire = timeout && (mode_q != MODE_RUN);

   assign enter_save = core_evt.power_save_instr && (mode_q == MODE_RUN);
   assign leave_save = (core_evt.exit_power_save && (mode_q != MODE_RUN)) || wake_fire;
   assign dev_reset_any = core_evt.device_reset || wdt_fire;

   // Every event that restarts the period
   assign counts_clear = dev_reset_any
      || core_evt.clock_switch_done
      || enter_save
      || leave_save
      || clear_ok
      || !running;

   ////////////////////////////////////////////////////////////////////////////
   // Counters

   // Counting does not look at the power mode, so sleep and idle keep running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_q <= '0;
      end else if (counts_clear) begin
         pre_cnt_q <= '0;
      end else if (pre_wrap) begin
         pre_cnt_q <= '0;
      end else if (low_power_rc_osc_tick) begin
         pre_cnt_q <= pre_cnt_q + PRE_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         post_cnt_q <= '0;
      end else if (counts_clear || timeout) begin
         post_cnt_q <= '0;
      end else if (pre_wrap) begin
         post_cnt_q <= post_cnt_q + POST_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power mode tracking

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RUN;
      end else begin
         case (mode_q)
            MODE_RUN: begin
               if (!core_evt.device_reset && enter_save) begin
                  mode_q <= core_evt.power_save_idle ? MODE_IDLE : MODE_SLEEP;
               end
            end
            MODE_SLEEP, MODE_IDLE: begin
               // Execution resumes after the power-save instruction
               if (core_evt.device_reset || leave_save) begin
                  mode_q <= MODE_RUN;
               end
            end
            default: begin
               mode_q <= MODE_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land at the edge where the master sees ack, while its request still stands
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign wr_rc = bus_wr && hit_f(wb_adr_i, REG_RESET_CTRL);
   assign wr_cfg = bus_wr && hit_f(wb_adr_i, REG_CONFIG_ONE);

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Read mux; unmapped words read as zero and still acknowledge
   always_comb begin
      rd_data = '0;
      if (hit_f(wb_adr_i, REG_RESET_CTRL)) begin
         rd_data[RC_IDLE_BIT] = idle_flag_q;
         rd_data[RC_SLEEP_BIT] = sleep_flag_q;
         rd_data[RC_TIMEOUT_BIT] = timeout_flag_q;
         rd_data[RC_SOFT_EN_BIT] = soft_enable_q;
      end else if (hit_f(wb_adr_i, REG_CONFIG_ONE)) begin
         rd_data[7:0] = config_q;
      end else if (hit_f(wb_adr_i, REG_STATUS)) begin
         rd_data[ST_RUNNING_BIT] = running;
         rd_data[ST_WINDOW_BIT] = window_open;
         rd_data[ST_SLEEP_BIT] = (mode_q == MODE_SLEEP);
         rd_data[ST_IDLE_BIT] = (mode_q == MODE_IDLE);
      end else if (hit_f(wb_adr_i, REG_COUNT)) begin
         rd_data[POST_W-1:0] = post_cnt_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration word

   // Unused bit is kept high so it always reads as one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         config_q <= CONFIG_RESET;
      end else if (wr_cfg) begin
         config_q <= wb_dat_i[7:0] | (8'h01 << CW_UNUSED_BIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset control register

   // Any device reset, including our own, drops the software enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_enable_q <= 1'b0;
      end else if (dev_reset_any) begin
         soft_enable_q <= 1'b0;
      end else if (wr_rc) begin
         soft_enable_q <= wb_dat_i[RC_SOFT_EN_BIT];
      end
   end

   // Sticky flag: hardware only sets, software writes zero to clear, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timeout_flag_q <= 1'b0;
      end else if (timeout || clear_early) begin
         timeout_flag_q <= 1'b1;
      end else if (wr_rc && !wb_dat_i[RC_TIMEOUT_BIT]) begin
         timeout_flag_q <= 1'b0;
      end
   end

   // Sleep and idle flags survive the watchdog wake until software clears them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_flag_q <= 1'b0;
      end else if (enter_save && !core_evt.power_save_idle) begin
         sleep_flag_q <= 1'b1;
      end else if (wr_rc && !wb_dat_i[RC_SLEEP_BIT]) begin
         sleep_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_flag_q <= 1'b0;
      end else if (enter_save && core_evt.power_save_idle) begin
         idle_flag_q <= 1'b1;
      end else if (wr_rc && !wb_dat_i[RC_IDLE_BIT]) begin
         idle_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Oscillator request follows the enable; one cycle late is harmless at 31 kHz
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_rc_osc_enable <= 1'b0;
      end else begin
         low_power_rc_osc_enable <= running;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_reset <= 1'b0;
      end else begin
         wdt_reset <= wdt_fire;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_wake <= 1'b0;
      end else begin
         wdt_wake <= wake_fire;
      end
   end

endmodule // windowed_watchdog_timer

// [verilog/wdt_pkg.sv]
// Shared constants, register map and carrier types for the windowed watchdog
package wdt_pkg;

   // Timing figures, nominal
   localparam int LOW_POWER_RC_OSC_FREQ_HZ = 31000;
   localparam int CLK_FREQ_HZ = 10000000;
   localparam int BASE_TIMEOUT_US_DIV32 = 1000;
   localparam int BASE_TIMEOUT_US_DIV128 = 4000;

   // Prescaler and postscaler geometry
   localparam int PRE_W = 7;
   localparam int POST_W = 15;
   localparam int ELAPSED_W = 22;
   localparam int TOTAL_W = 23;
   localparam int PRE_SHIFT_DIV32 = 5;
   localparam int PRE_SHIFT_DIV128 = 7;
   localparam logic [PRE_W-1:0] PRE_LAST_DIV32 = 7'h1f;
   localparam logic [PRE_W-1:0] PRE_LAST_DIV128 = 7'h7f;
   localparam logic [POST_W-1:0] POST_ONE = 15'h0001;

   // Wishbone geometry
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   // Register byte addresses
   localparam logic [ADR_W-1:0] REG_RESET_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] REG_CONFIG_ONE = 8'h04;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h08;
   localparam logic [ADR_W-1:0] REG_COUNT = 8'h0c;

   // Reset control register fields
   localparam int RC_IDLE_BIT = 2;
   localparam int RC_SLEEP_BIT = 3;
   localparam int RC_TIMEOUT_BIT = 4;
   localparam int RC_SOFT_EN_BIT = 5;

   // Configuration word one fields
   localparam int CW_PS_LO = 0;
   localparam int CW_PS_HI = 3;
   localparam int CW_PRESCALE_BIT = 4;
   localparam int CW_UNUSED_BIT = 5;
   localparam int CW_WINDOW_DIS_BIT = 6;
   localparam int CW_ENABLE_BIT = 7;
   localparam logic [7:0] CONFIG_RESET = 8'hff;

   // Status register fields
   localparam int ST_RUNNING_BIT = 0;
   localparam int ST_WINDOW_BIT = 1;
   localparam int ST_SLEEP_BIT = 2;
   localparam int ST_IDLE_BIT = 3;

   // Power state of the core as seen by the watchdog
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_SLEEP,
      MODE_IDLE
   } power_mode_e;

   // Events issued by the processor core, each a one-cycle pulse
   typedef struct packed {
      logic clear_watchdog_instr;
      logic power_save_instr;
      logic power_save_idle;
      logic clock_switch_done;
      logic exit_power_save;
      logic device_reset;
   } core_evt_s;

   // Decoded configuration word one
   typedef struct packed {
      logic config_enable;
      logic window_disable;
      logic prescale_ratio_select;
      logic [3:0] postscale_select;
   } wdt_cfg_s;

endpackage

// [sim/wdt_props.sv]
// Port-level assertions for the windowed watchdog timer
`timescale 1ns/1ps
module wdt_props
   import wdt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic low_power_rc_osc_clk_in,
   input wire core_evt_s core_evt,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [SEL_W-1:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   input wire logic [DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic low_power_rc_osc_enable,
   input wire logic wdt_reset,
   input wire logic wdt_wake
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Output pulses stand one cycle and never together
   rst_pulse_a: assert property (wdt_reset |=> !wdt_reset)
      else $error("watchdog reset pulse longer than one cycle");
   wake_pulse_a: assert property (wdt_wake |=> !wdt_wake)
      else $error("wake pulse longer than one cycle");
   wake_not_reset_a: assert property (!(wdt_reset && wdt_wake))
      else $error("wake and reset raised together");
   // A time-out can only come from a running, oscillator-fed watchdog
   osc_forced_a: assert property ((wdt_reset || wdt_wake) |-> $past(low_power_rc_osc_enable))
      else $error("time-out while oscillator was not forced on");
   // Bus answers exactly one cycle after the request is taken
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single pulse one cycle later");
   unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i[7:4] != 4'h0 |=> wb_dat_o == 32'h0)
      else $error("unmapped read returned nonzero data");
   // Count-clearing events leave no time-out in the following cycles
   reset_clears_a: assert property (core_evt.device_reset |=> !wdt_reset [*8])
      else $error("time-out right after a device reset");
   switch_clears_a: assert property (core_evt.clock_switch_done |=>
      !(wdt_reset || wdt_wake) [*8])
      else $error("time-out right after a clock switch");
   save_clears_a: assert property (core_evt.power_save_instr |=> !wdt_wake [*8])
      else $error("wake right after entering power save");
   exit_clears_a: assert property (core_evt.exit_power_save |=> !wdt_reset [*8])
      else $error("time-out right after leaving power save");
endmodule // wdt_props
bind windowed_watchdog_timer wdt_props i_props (.clk, .rst_n, .low_power_rc_osc_clk_in, .core_evt,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .low_power_rc_osc_enable, .wdt_reset, .wdt_wake);

// [sim/core_model.sv]
// Processor core and low-power oscillator model facing the watchdog
`timescale 1ns/1ps
module core_model
   import wdt_pkg::*;
(
   input wire logic clk,
   input wire logic wdt_wake,
   output core_evt_s core_evt,
   output logic low_power_rc_osc_clk
);
   core_evt_s evt_q = '0;
   logic resume_q = 1'b0;
   ////////////////////////////////////////
   // Oscillator runs free, much faster than nominal to keep runs short
   initial begin
      low_power_rc_osc_clk = 1'b0;
      #37;
      forever #425 low_power_rc_osc_clk = ~low_power_rc_osc_clk;
   end
   // A woken core resumes one cycle after the wake pulse
   always @(posedge clk) begin
      resume_q <= (wdt_wake === 1'b1);
   end
   assign core_evt = evt_q | core_evt_s'({4'h0, resume_q, 1'b0});
   // One instruction or event, issued as a single-cycle pulse
   task automatic issue(input core_evt_s e);
      @(posedge clk);
      evt_q <= e;
      @(posedge clk);
      evt_q <= '0;
   endtask
endmodule // core_model

// [sim/windowed_watchdog_timer_tb_top.sv]
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top import wdt_pkg::*; ();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [ADR_W-1:0] wb_adr = '0;
   logic [SEL_W-1:0] wb_sel = '0;
   logic [DAT_W-1:0] wb_wdat = '0;
   logic [DAT_W-1:0] wb_rdat;
   logic wb_ack, low_power_rc_osc_enable, wdt_reset, wdt_wake, low_power_rc_osc_clk;
   core_evt_s core_evt;
   int error_cnt = 0;
   int cmp_count = 0;
   int tick_cnt = 0;
   int cyc_cnt = 0;
   ////////////////////////////////////////
   initial begin
      forever #50 clk = ~clk;
   end
   core_model i_core (.clk(clk), .wdt_wake(wdt_wake), .core_evt(core_evt),
      .low_power_rc_osc_clk(low_power_rc_osc_clk));
   windowed_watchdog_timer i_dut (.clk(clk), .rst_n(rst_n), .low_power_rc_osc_clk_in(low_power_rc_osc_clk),
      .core_evt(core_evt), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .low_power_rc_osc_enable(low_power_rc_osc_enable), .wdt_reset(wdt_reset),
      .wdt_wake(wdt_wake));
   // Oscillator edges as a time base; a hang is cut short by the cycle ceiling
   always @(posedge low_power_rc_osc_clk) tick_cnt++;
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Classic cycle: hold everything until ack is seen at a rising edge
   // No wait limit here: only the cycle ceiling ends a hung transfer
   task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] a,
      input logic [DAT_W-1:0] d, input logic [SEL_W-1:0] s, output logic [DAT_W-1:0] q);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= s;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
      logic [DAT_W-1:0] q;
      wb_xfer(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rd_chk(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
      logic [DAT_W-1:0] q;
      wb_xfer(1'b0, a, 32'h0, 4'hf, q);
      chk(q, e);
   endtask
   // Waits for a reset or wake pulse, counting oscillator edges meanwhile
   task automatic wait_out(output int n, output logic r, output logic w);
      int t0, k;
      t0 = tick_cnt;
      r = 1'b0;
      w = 1'b0;
      for (k = 0; k < 5000 && !r && !w; k++) begin
         @(posedge clk);
         r = wdt_reset;
         w = wdt_wake;
      end
      n = tick_cnt - t0;
   endtask
   ////////////////////////////////////////
   task automatic t_reset_vals();
      logic [DAT_W-1:0] q;
      rd_chk(REG_CONFIG_ONE, 32'hff);
      // A write without the low byte lane must leave the configuration alone
      wb_xfer(1'b1, REG_CONFIG_ONE, 32'h0, 4'he, q);
      rd_chk(REG_CONFIG_ONE, 32'hff);
      rd_chk(REG_RESET_CTRL, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd_chk(8'h10, 32'h0);
      chk({31'h0, low_power_rc_osc_enable}, 32'h1);
   endtask
   // Period from a clock switch; the clear beforehand must hold off any time-out
   task automatic t_timeout(input logic [7:0] cfg, input int e);
      int n;
      logic r, w;
      wr(REG_CONFIG_ONE, {24'h0, cfg});
      rd_chk(REG_CONFIG_ONE, {24'h0, cfg});
      i_core.issue(6'h20);
      repeat (10) @(posedge low_power_rc_osc_clk);
      i_core.issue(6'h04);
      wait_out(n, r, w);
      chk({31'h0, r}, 32'h1);
      chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
      rd_chk(REG_RESET_CTRL, 32'h10);
      wr(REG_RESET_CTRL, 32'h0);
      rd_chk(REG_RESET_CTRL, 32'h0);
   endtask
   // Early clear resets at once; a clear inside the last quarter restarts the count
   task automatic t_window();
      int n;
      logic r, w;
      wr(REG_CONFIG_ONE, 32'ha0);
      i_core.issue(6'h20);
      repeat (4) @(posedge low_power_rc_osc_clk);
      i_core.issue(6'h20);
      wait_out(n, r, w);
      chk({31'h0, r}, 32'h1);
      chk(32'(n < 2), 32'h1);
      repeat (26) @(posedge low_power_rc_osc_clk);
      i_core.issue(6'h20);
      wait_out(n, r, w);
      chk({31'h0, r}, 32'h1);
      chk(32'(n >= 31 && n <= 33), 32'h1);
   endtask
   // Time-out in sleep or idle wakes instead of resetting
   task automatic t_sleep(input logic idle);
      int n;
      logic r, w;
      wr(REG_CONFIG_ONE, 32'he0);
      i_core.issue(idle ? 6'h18 : 6'h10);
      wait_out(n, r, w);
      chk({30'h0, r, w}, 32'h1);
      chk(32'(n >= 31 && n <= 33), 32'h1);
      rd_chk(REG_RESET_CTRL, idle ? 32'h14 : 32'h18);
      wr(REG_RESET_CTRL, 32'h0);
      rd_chk(REG_RESET_CTRL, 32'h0);
   endtask
   // Exit from sleep restarts the count; the next time-out is a reset, not a wake
   task automatic t_exit();
      int n;
      logic r, w;
      wr(REG_CONFIG_ONE, 32'he0);
      i_core.issue(6'h10);
      repeat (20) @(posedge low_power_rc_osc_clk);
      i_core.issue(6'h02);
      wait_out(n, r, w);
      chk({30'h0, r, w}, 32'h2);
      chk(32'(n >= 31 && n <= 33), 32'h1);
      rd_chk(REG_RESET_CTRL, 32'h18);
      wr(REG_RESET_CTRL, 32'h0);
   endtask
   // Software enable governs only when the configuration enable is low
   task automatic t_soft();
      wr(REG_CONFIG_ONE, 32'h60);
      repeat (3) @(posedge clk);
      chk({31'h0, low_power_rc_osc_enable}, 32'h0);
      rd_chk(REG_STATUS, 32'h0);
      rd_chk(REG_COUNT, 32'h0);
      wr(REG_RESET_CTRL, 32'h20);
      repeat (3) @(posedge clk);
      chk({31'h0, low_power_rc_osc_enable}, 32'h1);
      rd_chk(REG_STATUS, 32'h1);
      i_core.issue(6'h01);
      rd_chk(REG_RESET_CTRL, 32'h0);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_vals();
      t_timeout(8'he0, 32);
      t_timeout(8'hf0, 128);
      t_timeout(8'he3, 256);
      t_window();
      t_sleep(1'b0);
      t_sleep(1'b1);
      t_exit();
      t_soft();
      print_verdict();
   end
endmodule // windowed_watchdog_timer_tb_top
